// *** dv/ssb_exec_sva.sv ***
// ssb_exec_sva: port-level checks of the execution block
// assumes: bound to ssb_exec, one clock, synchronous active-high reset
`timescale 1ns/10ps
module ssb_exec_sva (
  input wire logic        SYS_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic [15:0] DATA_PTR_I,
  input wire logic [7:0]  MEM_RDATA_I,
  input wire logic [15:0] MEM_ADDR_O,
  input wire logic        MEM_RD_O,
  input wire logic [15:0] PC_O,
  input wire logic [7:0]  ACC_O,
  input wire logic        CARRY_FLAG_O,
  input wire logic        ILLEGAL_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // results only land after an operand read
  AST_ACC_AFTER_READ: assert property ($changed(ACC_O) |-> $past(MEM_RD_O))
    else $error("accumulator changed without operand read");
  AST_CARRY_AFTER_READ: assert property ($changed(CARRY_FLAG_O) |-> $past(MEM_RD_O))
    else $error("carry changed without operand read");
  // jumps of the program counter
  AST_JUMP_PAGE: assert property (($changed(PC_O) && PC_O != $past(PC_O) + 16'h0001)
    |-> PC_O[15:8] == $past(PC_O[15:8]))
    else $error("branch left its page");
  AST_JUMP_KEEPS_ACC: assert property (($changed(PC_O) && PC_O != $past(PC_O) + 16'h0001)
    |-> $stable(ACC_O) && $stable(CARRY_FLAG_O))
    else $error("branch altered accumulator or carry");
  AST_JUMP_AFTER_READ: assert property (($changed(PC_O) && PC_O != $past(PC_O) + 16'h0001)
    |-> $past(MEM_RD_O))
    else $error("branch without immediate read");
  AST_PAGE_BY_STEP: assert property (($changed(PC_O) && PC_O[15:8] != $past(PC_O[15:8]))
    |-> PC_O == $past(PC_O) + 16'h0001)
    else $error("page changed other than by increment");
  // read port behaviour
  AST_ADDR_HOLDS: assert property (!MEM_RD_O |-> $stable(MEM_ADDR_O))
    else $error("address moved without strobe");
  AST_READ_GAP: assert property (1'b1 |-> ##[0:3] MEM_RD_O)
    else $error("no read for four cycles");
endmodule
bind ssb_exec ssb_exec_sva ssb_exec_sva_inst (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .DATA_PTR_I(DATA_PTR_I), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_RD_O(MEM_RD_O), .PC_O(PC_O), .ACC_O(ACC_O), .CARRY_FLAG_O(CARRY_FLAG_O),
  .ILLEGAL_O(ILLEGAL_O));

// *** dv/ssb_mem_model.sv ***
// ssb_mem_model: byte memory whose byte stands while the strobe is high,
// so the block takes it at the edge that ends the strobe cycle
// assumes: strobe and address from ssb_exec, no wait states possible
`timescale 1ns/10ps
module ssb_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];
  // data stands during the strobe cycle, inverted otherwise so stale bytes never pass
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule

// *** dv/test_ssb_exec.sv ***
// test_ssb_exec: runs one program through the block, checking after each step
// assumes: memory model answers combinationally in the same cycle as the read strobe
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module test_ssb_exec;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] dptr = 16'h1000;
  logic [7:0]  rdata;
  logic [15:0] addr;
  logic [15:0] pc;
  logic [7:0]  acc;
  logic        rd;
  logic        carry;
  logic        ill;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  prog [20] = '{8'hFD, 8'h42, 8'hFF, 8'h0E, 8'hFD, 8'h33, 8'h7F, 8'h01, 8'hF5,
    8'h75, 8'h7D, 8'h10, 8'hF7, 8'h77, 8'h32, 8'h40, 8'hFF, 8'h24, 8'h32, 8'h20};
  ssb_exec ssb_exec_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst), .DATA_PTR_I(dptr),
    .MEM_RDATA_I(rdata), .MEM_ADDR_O(addr), .MEM_RD_O(rd), .PC_O(pc), .ACC_O(acc),
    .CARRY_FLAG_O(carry), .ILLEGAL_O(ill));
  ssb_mem_model ssb_mem_model_inst (.clk_i(clk), .rd_i(rd), .addr_i(addr), .rdata_o(rdata));
  initial forever #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // wait for the opcode fetch at a, then check the finished instruction
  task automatic step(input logic [15:0] a, input logic [7:0] e_acc, input logic e_c);
    int k = 0;
    while (!(rd === 1'b1 && addr === a) && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(pc, a + 16'h0001)
    `CHK(acc, e_acc)
    `CHK(carry, e_c)
    @(posedge clk);
    #1;
  endtask
  // all eight subtract forms, chained through the carry
  task automatic sub_chain();
    step(16'h0002, 8'h42, 1'b1);
    step(16'h0004, 8'h34, 1'b1);
    step(16'h0006, 8'hFF, 1'b0);
    step(16'h0008, 8'hFD, 1'b1);
    step(16'h0009, 8'h7A, 1'b0);
    step(16'h000A, 8'hFC, 1'b0);
    step(16'h000C, 8'h13, 1'b0);
    step(16'h000D, 8'h9C, 1'b0);
    step(16'h000E, 8'h24, 1'b1);
  endtask
  // short branches: untaken, taken, skip, page end and page start
  task automatic branch_chain();
    step(16'h0010, 8'h24, 1'b1);
    step(16'h0012, 8'h00, 1'b1);
    step(16'h0020, 8'h00, 1'b1);
    step(16'h0022, 8'h00, 1'b1);
    step(16'h00FE, 8'h00, 1'b1);
    step(16'h0100, 8'h00, 1'b1);
    step(16'h01FF, 8'h00, 1'b1);
    step(16'h0208, 8'h00, 1'b1);
    `CHK(ill, 1'b0)
    step(16'h0209, 8'h00, 1'b1);
    `CHK(ill, 1'b1)
  endtask
  // program image, reset, scenarios
  initial begin
    for (int i = 0; i < 20; i++) ssb_mem_model_inst.mem[i] = prog[i];
    ssb_mem_model_inst.mem[16'h0020] = 8'h38;
    ssb_mem_model_inst.mem[16'h0022] = 8'h30;
    ssb_mem_model_inst.mem[16'h0023] = 8'hFE;
    ssb_mem_model_inst.mem[16'h00FE] = 8'h38;
    ssb_mem_model_inst.mem[16'h0100] = 8'h30;
    ssb_mem_model_inst.mem[16'h0101] = 8'hFF;
    ssb_mem_model_inst.mem[16'h01FF] = 8'h30;
    ssb_mem_model_inst.mem[16'h0200] = 8'h08;
    ssb_mem_model_inst.mem[16'h1000] = 8'h77;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sub_chain();
    branch_chain();
    end_of_test();
  end
endmodule

// *** logic/ssb_alu_if.sv ***
// ssb_alu_if: operands and results between sequencer and subtract unit
// assumes: one clock domain, purely combinational unit behind it
`timescale 1ns/10ps
interface ssb_alu_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic       carry_in;
  logic [7:0] diff;
  logic       carry_out;

  modport ctrl (output minuend, output subtrahend, output carry_in,
                input diff, input carry_out);
  modport alu  (input minuend, input subtrahend, input carry_in,
                output diff, output carry_out);
endinterface

// *** logic/ssb_exec.sv ***
// ssb_exec: execution of the subtract group and the short-branch group
// assumes: memory presenting MEM_RDATA_I in the same cycle that MEM_RD_O is high,
// program counter held here, data pointer supplied from outside on DATA_PTR_I
`timescale 1ns/10ps
module ssb_exec (
  input  wire logic        SYS_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [15:0] DATA_PTR_I,
  input  wire logic [7:0]  MEM_RDATA_I,
  output logic      [15:0] MEM_ADDR_O,
  output logic             MEM_RD_O,
  output logic      [15:0] PC_O,
  output logic      [7:0]  ACC_O,
  output logic             CARRY_FLAG_O,
  output logic             ILLEGAL_O
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    ssb_pkg::ssb_state_t state;
    logic [15:0]         pc;
    logic [7:0]          acc;
    logic                carry_flag;
    logic [7:0]          opcode;
    logic [15:0]         addr;
    logic                rd;
    logic                illegal;
  } ssb_regs_t;

  ssb_regs_t st_r;
  ssb_regs_t st_nxt;

  ssb_alu_if alu_bus ();

  logic is_branch;
  logic is_sub;
  logic uses_imm;
  logic reverse;
  logic with_borrow;
  logic take;
  logic [15:0] pc_inc;

  ssb_sub_unit u_sub (
    .port_a (alu_bus)
  );

  // ---------------------------------------------------------------
  // opcode decode
  // ---------------------------------------------------------------
  // group membership and operand selection
  always_comb begin
    is_branch   = (st_r.opcode[7:4] == ssb_pkg::BR_GROUP);
    is_sub      = (st_r.opcode == ssb_pkg::OP_REV_SUB)
               || (st_r.opcode == ssb_pkg::OP_REV_SUB_IMM)
               || (st_r.opcode == ssb_pkg::OP_REV_SUB_BRW)
               || (st_r.opcode == ssb_pkg::OP_REV_SUB_BRW_IM)
               || (st_r.opcode == ssb_pkg::OP_FWD_SUB)
               || (st_r.opcode == ssb_pkg::OP_FWD_SUB_IMM)
               || (st_r.opcode == ssb_pkg::OP_FWD_SUB_BRW)
               || (st_r.opcode == ssb_pkg::OP_FWD_SUB_BRW_IM);
    uses_imm    = st_r.opcode[3];     // immediate forms have bit 3 set
    reverse     = ~st_r.opcode[1];    // F5/FD/75/7D reverse, F7/FF/77/7F forward
    with_borrow = ~st_r.opcode[7];    // 7x forms use the carry flag
  end

  // branch condition, remaining codes not handled here never branch
  always_comb begin
    case (st_r.opcode[3:0])
      ssb_pkg::COND_ALWAYS:  take = 1'b1;
      ssb_pkg::COND_NEVER:   take = 1'b0;
      ssb_pkg::COND_ZERO:    take = (st_r.acc == 8'h00);
      ssb_pkg::COND_NONZERO: take = (st_r.acc != 8'h00);
      ssb_pkg::COND_CARRY:   take = st_r.carry_flag;
      ssb_pkg::COND_NOCARRY: take = ~st_r.carry_flag;
      default:               take = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // subtract operands
  // ---------------------------------------------------------------
  // reverse forms subtract acc from memory, forward the other way round
  always_comb begin
    alu_bus.minuend    = reverse ? MEM_RDATA_I : st_r.acc;
    alu_bus.subtrahend = reverse ? st_r.acc    : MEM_RDATA_I;
    alu_bus.carry_in   = with_borrow ? st_r.carry_flag : 1'b1;
  end

  // full 16-bit increment carries into the next page
  assign pc_inc = st_r.pc + 16'h0001;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // fetch opcode, fetch operand, then execute
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rd   = 1'b0;
    case (st_r.state)
      ssb_pkg::ST_FETCH: begin
        st_nxt.addr  = st_r.pc;
        st_nxt.rd    = 1'b1;
        st_nxt.pc    = pc_inc;
        st_nxt.state = ssb_pkg::ST_DECODE;
      end
      ssb_pkg::ST_DECODE: begin
        st_nxt.opcode = MEM_RDATA_I;
        st_nxt.state  = ssb_pkg::ST_WAIT;
      end
      ssb_pkg::ST_WAIT: begin
        st_nxt.illegal = ~(is_branch | is_sub);
        if (is_branch || (is_sub && uses_imm)) begin
          // immediate byte read through pc before evaluating
          st_nxt.addr  = st_r.pc;
          st_nxt.rd    = 1'b1;
          st_nxt.state = ssb_pkg::ST_OPERAND;
        end else if (is_sub) begin
          st_nxt.addr  = DATA_PTR_I;
          st_nxt.rd    = 1'b1;
          st_nxt.state = ssb_pkg::ST_OPERAND;
        end else begin
          st_nxt.state = ssb_pkg::ST_FETCH;
        end
      end
      ssb_pkg::ST_OPERAND: begin
        st_nxt.state = ssb_pkg::ST_FETCH;
        if (is_branch) begin
          if (take) begin
            // high byte kept from the immediate byte's address
            st_nxt.pc = {st_r.pc[15:8], MEM_RDATA_I};
          end else begin
            st_nxt.pc = pc_inc;
          end
        end else begin
          st_nxt.acc        = alu_bus.diff;
          st_nxt.carry_flag = alu_bus.carry_out;
          if (uses_imm) begin
            st_nxt.pc = pc_inc;
          end
        end
      end
      default: begin
        st_nxt.state = ssb_pkg::ST_FETCH;
      end
    endcase
  end

  // register the state record
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      st_r            <= '0;
      st_r.state      <= ssb_pkg::ST_FETCH;
      st_r.pc         <= ssb_pkg::RST_PC;
      st_r.acc        <= ssb_pkg::RST_ACC;
      st_r.carry_flag <= ssb_pkg::RST_CARRY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign MEM_ADDR_O   = st_r.addr;
  assign MEM_RD_O     = st_r.rd;
  assign PC_O         = st_r.pc;
  assign ACC_O        = st_r.acc;
  assign CARRY_FLAG_O = st_r.carry_flag;
  assign ILLEGAL_O    = st_r.illegal;

endmodule

// *** logic/ssb_pkg.sv ***
// ssb_pkg: constants and types for the subtract and short-branch execution block
// assumes: 8-bit data, 16-bit program counter, one processor clock
package ssb_pkg;

  // opcodes of the subtract group
  localparam logic [7:0] OP_REV_SUB        = 8'hF5;
  localparam logic [7:0] OP_REV_SUB_IMM    = 8'hFD;
  localparam logic [7:0] OP_REV_SUB_BRW    = 8'h75;
  localparam logic [7:0] OP_REV_SUB_BRW_IM = 8'h7D;
  localparam logic [7:0] OP_FWD_SUB        = 8'hF7;
  localparam logic [7:0] OP_FWD_SUB_IMM    = 8'hFF;
  localparam logic [7:0] OP_FWD_SUB_BRW    = 8'h77;
  localparam logic [7:0] OP_FWD_SUB_BRW_IM = 8'h7F;

  // short-branch group: upper nibble and condition codes
  localparam logic [3:0] BR_GROUP          = 4'h3;
  localparam logic [3:0] COND_ALWAYS       = 4'h0;
  localparam logic [3:0] COND_ZERO         = 4'h2;
  localparam logic [3:0] COND_NEVER        = 4'h8;
  localparam logic [3:0] COND_NONZERO      = 4'hA;
  localparam logic [3:0] COND_CARRY        = 4'h3;
  localparam logic [3:0] COND_NOCARRY      = 4'hB;

  // reset values
  localparam logic [15:0] RST_PC           = 16'h0000;
  localparam logic [7:0]  RST_ACC          = 8'h00;
  localparam logic        RST_CARRY        = 1'b0;

  // sequencer states, gray coded along fetch -> decode -> wait -> operand
  typedef enum logic [1:0] {
    ST_FETCH   = 2'b00,
    ST_DECODE  = 2'b01,
    ST_WAIT    = 2'b11,
    ST_OPERAND = 2'b10
  } ssb_state_t;

endpackage

// *** logic/ssb_sub_unit.sv ***
// ssb_sub_unit: two's complement subtractor, minuend + ~subtrahend + carry
// assumes: caller supplies carry_in 1 for plain subtract, carry flag for borrow forms
`timescale 1ns/10ps
module ssb_sub_unit (
  ssb_alu_if.alu port_a
);

  logic [8:0] sum;

  // add complemented subtrahend; carry out of bit 7 into sum bit 8 means no borrow
  always_comb begin
    sum = {1'b0, port_a.minuend} + {1'b0, ~port_a.subtrahend} + {8'h00, port_a.carry_in};
  end

  assign port_a.diff      = sum[7:0];
  assign port_a.carry_out = sum[8];

endmodule
